// [logic/mrs_pair_buffer.v]
// Two-entry valid/ready buffer on the response byte path
`timescale 1ns/1ns
module mrs_pair_buffer (
	clk,
	rst,
	in_data,
	in_valid,
	in_ready,
	out_data,
	out_valid,
	out_ready
);
`include "mrs_regs.vh"
	input wire clk;
	input wire rst;
	input wire [`MRS_BUF_W-1:0] in_data;
	input wire in_valid;
	output wire in_ready;
	output wire [`MRS_BUF_W-1:0] out_data;
	output wire out_valid;
	input wire out_ready;

	reg [`MRS_BUF_W-1:0] slot_reg [0:1];
	reg wptr_reg;
	reg rptr_reg;
	reg [1:0] count_reg;
	wire push;
	wire pop;

	// Full and empty come straight from the fill count
	assign in_ready = (count_reg != `MRS_BUF_DEPTH);
	assign out_valid = (count_reg != 2'h0);
	assign out_data = slot_reg[rptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	// A stalled receiver lets both slots fill, which then holds off the source
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			count_reg <= 2'h0;
			slot_reg[0] <= {`MRS_BUF_W{1'b0}};
			slot_reg[1] <= {`MRS_BUF_W{1'b0}};
		end
		else
		begin
			if (push)
			begin
				slot_reg[wptr_reg] <= in_data;
				wptr_reg <= ~wptr_reg;
			end
			if (pop)
				rptr_reg <= ~rptr_reg;
			if (push & ~pop)
				count_reg <= count_reg + 2'h1;
			else if (pop & ~push)
				count_reg <= count_reg - 2'h1;
		end
	end
endmodule

// [logic/mrs_regs.vh]
// Constants shared by the Modbus RTU request checker and its output buffer
`ifndef MRS_REGS_VH
`define MRS_REGS_VH
// Function codes and exception answers
`define MRS_FC_READ 8'h03
`define MRS_FC_WRITE 8'h10
`define MRS_FC_ID 8'h11
`define MRS_EXC_NONE 8'h00
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_EXC_FLAG 8'h80
// Request limits
`define MRS_MAX_RD 16'h007d
`define MRS_MAX_WR 16'h0010
`define MRS_TOP_ADDR 17'h0ffff
// Node, rate and framing settings
`define MRS_ADDR_MIN 8'h01
`define MRS_ADDR_MAX 8'hf7
`define MRS_ADDR_DEF 8'h01
`define MRS_BAUD_DEF 3'h0
`define MRS_BAUD_LAST 3'h5
`define MRS_FRAME_DEF 2'h3
// Holding register numbers of mapped items
`define MRS_REG_UCODE 17'h00002
`define MRS_REG_SPARE 17'h00004
`define MRS_REG_FCODE 17'h00006
`define MRS_REG_CMD 17'h00008
`define MRS_REG_RO 17'h0000a
`define MRS_REG_USR 17'h00100
`define MRS_REG_FAC 17'h00200
`define MRS_USR_WORDS 17'h00008
`define MRS_FAC_WORDS 17'h00004
`define MRS_ITEM_WORDS 17'h00002
// Unlock code ranges
`define MRS_UCODE_MAX 32'h0000270f
`define MRS_FCODE_MAX 32'h05f5e0ff
// Item kinds
`define MRS_K_HOLE 3'h0
`define MRS_K_UCODE 3'h1
`define MRS_K_SPARE 3'h2
`define MRS_K_FCODE 3'h3
`define MRS_K_CMD 3'h4
`define MRS_K_RO 3'h5
`define MRS_K_USR 3'h6
`define MRS_K_FAC 3'h7
// Request byte positions
`define MRS_IDX_ADDR 9'h000
`define MRS_IDX_FC 9'h001
`define MRS_IDX_SHI 9'h002
`define MRS_IDX_SLO 9'h003
`define MRS_IDX_QHI 9'h004
`define MRS_IDX_QLO 9'h005
`define MRS_IDX_BC 9'h006
`define MRS_IDX_DATA 9'h007
`define MRS_IDX_SAT 9'h1ff
// Response lengths and identification answer (ident value is arbitrary)
`define MRS_LEN_EXC 9'h003
`define MRS_LEN_WR 9'h006
`define MRS_LEN_ID 9'h005
`define MRS_LEN_RDHDR 9'h003
`define MRS_ID_BYTES 8'h02
`define MRS_ID_CODE 8'h5a
`define MRS_RUN_ON 8'hff
// Output buffer shape
`define MRS_BUF_W 9
`define MRS_BUF_DEPTH 2'h2
`endif

// [logic/mrs_request_checker.v]
// Modbus RTU slave request checker for the holding-register map
// Function
// R01 - Node address settable 1 to 247, default 1 after defaults load.
// R02 - Rate one of six choices, default 9600; master uses same rate.
// R03 - Framing even/1, odd/1, none/2 or none/1; default none/1.
// R04 - Only holding registers are served.
// R05 - Accept function codes 3, 16 and 17 only.
// R06 - Code 17 returns identification and never an exception.
// R07 - Read quantity below 1 or above 125 gives exception 3.
// R08 - Request beyond maximum message size gives exception 2.
// R09 - Range above or wrapping past 0xFFFF gives exception 2.
// R10 - Reads return data; end splitting an item gives exception 2.
// R11 - Read touching a hole gives exception 2.
// R12 - Write not starting at an item start gives exception 2.
// R13 - Write covering a hole gives exception 2.
// R14 - Write to read-only or locked items gives exception 2.
// R15 - Written values are stored unchecked.
// R16 - 32-bit item: low word even, write must cover both words.
// R17 - Command item reads meaningless; writing 1 to both words acts.
// R18 - Master scales integers by ten to minus decimal_count.
// R19 - User and factory sections locked until a matching code is written.
// R20 - Code register reads 0 when locked and 1 when unlocked.
// R21 - Non-matching code write relocks its section.
// R22 - Register N travels as address N minus one.
// R23 - Frame: address, function, up to 252 data bytes, check value.
// R24 - Transmit only in reply to a request addressed here.
// R25 - Exception reply echoes address, function with top bit, code.
// R26 - Bad check value or foreign address: discard silently.
`timescale 1ns/1ns
module mrs_request_checker (
	clk,
	rst,
	rx_byte,
	rx_valid,
	rx_ready,
	rx_eof,
	rx_crc_ok,
	tx_byte,
	tx_last,
	tx_valid,
	tx_ready,
	cfg_node_addr,
	cfg_baud_sel,
	cfg_frame_sel,
	cfg_load_defaults,
	user_pass,
	factory_pass,
	ro_item,
	node_addr,
	baud_sel,
	frame_sel,
	user_unlocked,
	factory_unlocked,
	clear_totals
);
`include "mrs_regs.vh"
	input wire clk;
	input wire rst;
	input wire [7:0] rx_byte;
	input wire rx_valid;
	output wire rx_ready;
	input wire rx_eof;
	input wire rx_crc_ok;
	output wire [7:0] tx_byte;
	output wire tx_last;
	output wire tx_valid;
	input wire tx_ready;
	input wire [7:0] cfg_node_addr;
	input wire [2:0] cfg_baud_sel;
	input wire [1:0] cfg_frame_sel;
	input wire cfg_load_defaults;
	input wire [31:0] user_pass;
	input wire [31:0] factory_pass;
	input wire [31:0] ro_item;
	output wire [7:0] node_addr;
	output wire [2:0] baud_sel;
	output wire [1:0] frame_sel;
	output wire user_unlocked;
	output wire factory_unlocked;
	output wire clear_totals;

	localparam S_RX = 2'h0;
	localparam S_CHECK = 2'h1;
	localparam S_EXEC = 2'h2;
	localparam S_TX = 2'h3;

	reg [1:0] state_reg;
	reg [8:0] idx_reg;
	reg [7:0] fc_reg;
	reg [15:0] start_reg;
	reg [15:0] qty_reg;
	reg [7:0] bc_reg;
	reg [7:0] exc_reg;
	reg [15:0] cnt_reg;
	reg [8:0] tcnt_reg;
	reg addr_hit_reg;
	reg user_unl_reg;
	reg fac_unl_reg;
	reg clr_reg;
	reg [7:0] node_reg;
	reg [2:0] baud_reg;
	reg [1:0] frame_reg;
	reg [15:0] wbuf [0:15];
	reg [15:0] usr_mem [0:7];
	reg [15:0] fac_mem [0:3];
	reg [7:0] pre_exc;
	reg [8:0] tlen;
	reg [15:0] rd_word;
	reg [7:0] tx_mux;
	reg chk_err;
	integer i;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Register number of the n-th word of a request; the message carries N minus one
	function [16:0] reg_num;
		input [15:0] base;
		input [15:0] off;
		begin
			reg_num = {1'b0, base} + {1'b0, off} + 17'h00001; // [R22]
		end
	endfunction

	// Item kind of a register number; anything outside the map is a hole
	function [2:0] reg_kind;
		input [16:0] r;
		begin
			if (r >= `MRS_REG_UCODE && r < `MRS_REG_UCODE + `MRS_ITEM_WORDS)
				reg_kind = `MRS_K_UCODE;
			else if (r >= `MRS_REG_SPARE && r < `MRS_REG_SPARE + `MRS_ITEM_WORDS)
				reg_kind = `MRS_K_SPARE;
			else if (r >= `MRS_REG_FCODE && r < `MRS_REG_FCODE + `MRS_ITEM_WORDS)
				reg_kind = `MRS_K_FCODE;
			else if (r >= `MRS_REG_CMD && r < `MRS_REG_CMD + `MRS_ITEM_WORDS)
				reg_kind = `MRS_K_CMD;
			else if (r >= `MRS_REG_RO && r < `MRS_REG_RO + `MRS_ITEM_WORDS)
				reg_kind = `MRS_K_RO;
			else if (r >= `MRS_REG_USR && r < `MRS_REG_USR + `MRS_USR_WORDS)
				reg_kind = `MRS_K_USR;
			else if (r >= `MRS_REG_FAC && r < `MRS_REG_FAC + `MRS_FAC_WORDS)
				reg_kind = `MRS_K_FAC;
			else
				reg_kind = `MRS_K_HOLE; // Coils and input blocks map nowhere [R04]
		end
	endfunction

	wire [16:0] end_num = {1'b0, start_reg} + {1'b0, qty_reg} - 17'h00001;
	wire [16:0] ck_num = reg_num(start_reg, cnt_reg);
	wire [2:0] ck_kind = reg_kind(ck_num);
	wire ck_first = (cnt_reg == 16'h0000);
	wire ck_last = (cnt_reg == qty_reg - 16'h0001);
	wire [3:0] wi = cnt_reg[3:0];
	wire [3:0] wi_prev = cnt_reg[3:0] - 4'h1;
	wire [31:0] wr_pair = {wbuf[wi], wbuf[wi_prev]};
	wire [16:0] usr_off = ck_num - `MRS_REG_USR;
	wire [16:0] fac_off = ck_num - `MRS_REG_FAC;
	wire [8:0] d_pos = idx_reg - `MRS_IDX_DATA;
	wire [8:0] t_pos = tcnt_reg - `MRS_LEN_RDHDR;
	wire [16:0] rd_num = reg_num(start_reg, {8'h00, t_pos[8:1]});
	wire [16:0] rd_usr = rd_num - `MRS_REG_USR;
	wire [16:0] rd_fac = rd_num - `MRS_REG_FAC;
	wire frame_ok = rx_crc_ok & addr_hit_reg & (idx_reg > `MRS_IDX_FC);
	wire buf_ready;

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	// Out-of-range settings are ignored so the link never runs on a bad value
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			node_reg <= `MRS_ADDR_DEF;
			baud_reg <= `MRS_BAUD_DEF;
			frame_reg <= `MRS_FRAME_DEF;
		end
		else if (cfg_load_defaults)
		begin
			node_reg <= `MRS_ADDR_DEF; // [R01]
			baud_reg <= `MRS_BAUD_DEF; // [R02]
			frame_reg <= `MRS_FRAME_DEF; // [R03]
		end
		else
		begin
			if (cfg_node_addr >= `MRS_ADDR_MIN && cfg_node_addr <= `MRS_ADDR_MAX)
				node_reg <= cfg_node_addr; // [R01]
			if (cfg_baud_sel <= `MRS_BAUD_LAST)
				baud_reg <= cfg_baud_sel; // [R02]
			frame_reg <= cfg_frame_sel; // All four framing codes are legal [R03]
		end
	end

	// ----------------------------------------
	// Checks made once the whole request is in
	// ----------------------------------------
	always @*
	begin
		pre_exc = `MRS_EXC_NONE;
		case (fc_reg)
		`MRS_FC_READ:
		begin
			if (qty_reg == 16'h0000 || qty_reg > `MRS_MAX_RD)
				pre_exc = `MRS_EXC_VALUE; // [R07]
			else if (end_num > `MRS_TOP_ADDR)
				pre_exc = `MRS_EXC_ADDR; // [R09]
		end
		`MRS_FC_WRITE:
		begin
			if (qty_reg == 16'h0000)
				pre_exc = `MRS_EXC_VALUE;
			else if (qty_reg > `MRS_MAX_WR)
				pre_exc = `MRS_EXC_ADDR; // Larger than this device's write message [R08]
			else if ({qty_reg[6:0], 1'b0} != bc_reg || idx_reg != `MRS_IDX_DATA + {1'b0, bc_reg})
				pre_exc = `MRS_EXC_VALUE;
			else if (end_num > `MRS_TOP_ADDR)
				pre_exc = `MRS_EXC_ADDR; // [R09]
		end
		`MRS_FC_ID:
			pre_exc = `MRS_EXC_NONE; // Identification has no failure case [R06]
		default:
			pre_exc = `MRS_EXC_FUNC; // [R05]
		endcase
	end

	// Per-register test, one register a cycle
	always @*
	begin
		chk_err = 1'b0;
		if (ck_kind == `MRS_K_HOLE)
			chk_err = 1'b1; // [R11] [R13]
		if (ck_kind == `MRS_K_USR && !user_unl_reg)
			chk_err = 1'b1; // [R19]
		if (ck_kind == `MRS_K_FAC && !fac_unl_reg)
			chk_err = 1'b1; // [R19]
		if (ck_last && !ck_num[0])
			chk_err = 1'b1; // End stops on a low word [R10] [R16]
		if (fc_reg == `MRS_FC_WRITE)
		begin
			if (ck_first && ck_num[0])
				chk_err = 1'b1; // [R12] [R16]
			if (ck_kind == `MRS_K_RO)
				chk_err = 1'b1; // [R14]
		end
	end

	// ----------------------------------------
	// Request sequencer
	// ----------------------------------------
	// Writes only start after every register passed, so a refused write changes nothing
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= S_RX;
			idx_reg <= 9'h000;
			fc_reg <= 8'h00;
			start_reg <= 16'h0000;
			qty_reg <= 16'h0000;
			bc_reg <= 8'h00;
			exc_reg <= `MRS_EXC_NONE;
			cnt_reg <= 16'h0000;
			tcnt_reg <= 9'h000;
			addr_hit_reg <= 1'b0;
			user_unl_reg <= 1'b0;
			fac_unl_reg <= 1'b0;
			clr_reg <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
				wbuf[i] <= 16'h0000;
			for (i = 0; i < 8; i = i + 1)
				usr_mem[i] <= 16'h0000;
			for (i = 0; i < 4; i = i + 1)
				fac_mem[i] <= 16'h0000;
		end
		else
		begin
			clr_reg <= 1'b0;
			case (state_reg)
			S_RX:
			begin
				if (rx_eof)
				begin
					idx_reg <= 9'h000;
					cnt_reg <= 16'h0000;
					tcnt_reg <= 9'h000;
					exc_reg <= pre_exc;
					if (frame_ok)
						state_reg <= (fc_reg == `MRS_FC_ID) ? S_TX : S_CHECK; // [R24] [R26]
				end
				else if (rx_valid)
				begin
					if (idx_reg != `MRS_IDX_SAT)
						idx_reg <= idx_reg + 9'h001;
					case (idx_reg)
					`MRS_IDX_ADDR: addr_hit_reg <= (rx_byte == node_reg); // [R26]
					`MRS_IDX_FC: fc_reg <= rx_byte;
					`MRS_IDX_SHI: start_reg[15:8] <= rx_byte;
					`MRS_IDX_SLO: start_reg[7:0] <= rx_byte;
					`MRS_IDX_QHI: qty_reg[15:8] <= rx_byte;
					`MRS_IDX_QLO: qty_reg[7:0] <= rx_byte;
					`MRS_IDX_BC: bc_reg <= rx_byte;
					default:
					begin
						if (d_pos[8:5] == 4'h0 && !d_pos[0])
							wbuf[d_pos[4:1]][15:8] <= rx_byte;
						else if (d_pos[8:5] == 4'h0)
							wbuf[d_pos[4:1]][7:0] <= rx_byte;
					end
					endcase
				end
			end
			S_CHECK:
			begin
				if (exc_reg != `MRS_EXC_NONE)
					state_reg <= S_TX;
				else if (chk_err)
				begin
					exc_reg <= `MRS_EXC_ADDR;
					state_reg <= S_TX;
				end
				else if (ck_last)
				begin
					cnt_reg <= 16'h0000;
					state_reg <= (fc_reg == `MRS_FC_WRITE) ? S_EXEC : S_TX;
				end
				else
					cnt_reg <= cnt_reg + 16'h0001;
			end
			S_EXEC:
			begin
				// Values land as sent, with no range test [R15]
				case (ck_kind)
				`MRS_K_USR: usr_mem[usr_off[2:0]] <= wbuf[wi]; // [R15]
				`MRS_K_FAC: fac_mem[fac_off[1:0]] <= wbuf[wi]; // [R15]
				`MRS_K_UCODE:
					if (ck_num[0])
						user_unl_reg <= (wr_pair == user_pass) && (wr_pair <= `MRS_UCODE_MAX); // [R19] [R21]
				`MRS_K_FCODE:
					if (ck_num[0])
						fac_unl_reg <= (wr_pair == factory_pass) && (wr_pair <= `MRS_FCODE_MAX); // [R19] [R21]
				`MRS_K_CMD:
					if (ck_num[0] && wr_pair == {16'h0001, 16'h0001})
						clr_reg <= 1'b1; // [R17]
				default:
					clr_reg <= 1'b0;
				endcase
				if (ck_last)
					state_reg <= S_TX;
				else
					cnt_reg <= cnt_reg + 16'h0001;
			end
			S_TX:
			begin
				if (buf_ready)
				begin
					tcnt_reg <= tcnt_reg + 9'h001;
					if (tcnt_reg == tlen - 9'h001)
						state_reg <= S_RX;
				end
			end
			default:
				state_reg <= S_RX;
			endcase
		end
	end

	// ----------------------------------------
	// Response assembly
	// ----------------------------------------
	// Length of the reply without its check value, which the link layer adds [R23]
	always @*
	begin
		if (exc_reg != `MRS_EXC_NONE)
			tlen = `MRS_LEN_EXC;
		else if (fc_reg == `MRS_FC_WRITE)
			tlen = `MRS_LEN_WR;
		else if (fc_reg == `MRS_FC_ID)
			tlen = `MRS_LEN_ID;
		else
			tlen = `MRS_LEN_RDHDR + {qty_reg[7:0], 1'b0};
	end

	// Word for the register being returned; codes never reveal their value
	always @*
	begin
		case (reg_kind(rd_num))
		`MRS_K_UCODE: rd_word = {15'h0000, user_unl_reg & ~rd_num[0]}; // [R20]
		`MRS_K_FCODE: rd_word = {15'h0000, fac_unl_reg & ~rd_num[0]}; // [R20]
		`MRS_K_RO: rd_word = rd_num[0] ? ro_item[31:16] : ro_item[15:0]; // [R16]
		`MRS_K_USR: rd_word = usr_mem[rd_usr[2:0]];
		`MRS_K_FAC: rd_word = fac_mem[rd_fac[1:0]];
		default: rd_word = 16'h0000; // Command and spare items read as zero [R17]
		endcase
	end

	// Byte picked for the current reply position
	always @*
	begin
		tx_mux = 8'h00;
		if (tcnt_reg == `MRS_IDX_ADDR)
			tx_mux = node_reg;
		else if (tcnt_reg == `MRS_IDX_FC)
			tx_mux = (exc_reg != `MRS_EXC_NONE) ? (fc_reg | `MRS_EXC_FLAG) : fc_reg; // [R25]
		else if (exc_reg != `MRS_EXC_NONE)
			tx_mux = exc_reg; // [R25]
		else if (fc_reg == `MRS_FC_ID)
		begin
			case (tcnt_reg)
			`MRS_IDX_SHI: tx_mux = `MRS_ID_BYTES;
			`MRS_IDX_SLO: tx_mux = `MRS_ID_CODE; // [R06]
			default: tx_mux = `MRS_RUN_ON;
			endcase
		end
		else if (fc_reg == `MRS_FC_WRITE)
		begin
			case (tcnt_reg)
			`MRS_IDX_SHI: tx_mux = start_reg[15:8];
			`MRS_IDX_SLO: tx_mux = start_reg[7:0];
			`MRS_IDX_QHI: tx_mux = qty_reg[15:8];
			default: tx_mux = qty_reg[7:0];
			endcase
		end
		else if (tcnt_reg == `MRS_IDX_SHI)
			tx_mux = {qty_reg[6:0], 1'b0};
		else
			tx_mux = t_pos[0] ? rd_word[7:0] : rd_word[15:8]; // High byte first [R10]
	end

	// Reply bytes only flow in the answer state, so nothing leaves unasked [R24]
	mrs_pair_buffer u_buf (
		.clk(clk),
		.rst(rst),
		.in_data({tcnt_reg == tlen - 9'h001, tx_mux}),
		.in_valid(state_reg == S_TX),
		.in_ready(buf_ready),
		.out_data({tx_last, tx_byte}),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	assign rx_ready = (state_reg == S_RX);
	assign node_addr = node_reg;
	assign baud_sel = baud_reg;
	assign frame_sel = frame_reg;
	assign user_unlocked = user_unl_reg;
	assign factory_unlocked = fac_unl_reg;
	assign clear_totals = clr_reg;
endmodule

// [tb/mrs_master_model.sv]
// Bus master stand-in: sends request frames and collects reply bytes
`timescale 1ns/1ns
module mrs_master_model (
	input wire clk,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_eof,
	output logic rx_crc_ok,
	input wire [7:0] tx_byte,
	input wire tx_last,
	input wire tx_valid,
	output logic tx_ready,
	input wire slow
);
	logic [7:0] rsp[$];
	int n_last = 0;
	// Rebuild a 32-bit item from the reply bytes at k: low word first, then high.
	// With decimal_count 0 the scale of ten to the minus decimal_count is one
	function automatic logic [31:0] item32(input int k);
		return {rsp[k+2], rsp[k+3], rsp[k], rsp[k+1]};
	endfunction
	initial
	begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		rx_eof = 1'b0;
		rx_crc_ok = 1'b0;
		tx_ready = 1'b1;
	end
	// Reply sink; a slow master takes a byte only every other cycle
	always @(posedge clk)
	begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready)
		begin
			rsp.push_back(tx_byte);
			if (tx_last)
				n_last++;
		end
	end
	// Whole frame back to back, then the end strobe with the check verdict
	task automatic send(input logic [7:0] b[$], input logic ok);
		foreach (b[i])
		begin
			rx_byte <= b[i];
			rx_valid <= 1'b1;
			@(posedge clk);
		end
		rx_byte <= ~b[b.size()-1]; // Idle data must not echo the last byte
		rx_valid <= 1'b0;
		rx_eof <= 1'b1;
		rx_crc_ok <= ok;
		@(posedge clk);
		rx_eof <= 1'b0;
	endtask
endmodule

// [tb/mrs_request_checker_bench.sv]
// Self-checking bench for the Modbus request checker
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module mrs_request_checker_bench;
	logic clk, rst, slow, rx_valid, rx_eof, rx_crc_ok, rx_ready, tx_last, tx_valid, tx_ready;
	logic [7:0] rx_byte, tx_byte, cfg_node_addr, node_addr, na;
	logic [2:0] cfg_baud_sel, baud_sel;
	logic [1:0] cfg_frame_sel, frame_sel;
	logic cfg_load_defaults, user_unlocked, factory_unlocked, clear_totals;
	logic [7:0] req[$], exp[$];
	int err_total = 0;
	int n_compared = 0;
	int n_clear = 0;
	mrs_request_checker i_mrs_request_checker (.clk, .rst, .rx_byte, .rx_valid, .rx_ready,
		.rx_eof, .rx_crc_ok, .tx_byte, .tx_last, .tx_valid, .tx_ready, .cfg_node_addr,
		.cfg_baud_sel, .cfg_frame_sel, .cfg_load_defaults, .user_pass(32'h00001234),
		.factory_pass(32'h00989680), .ro_item(32'h89abcdef), .node_addr, .baud_sel,
		.frame_sel, .user_unlocked, .factory_unlocked, .clear_totals);
	mrs_master_model i_mrs_master_model (.clk, .rx_byte, .rx_valid, .rx_eof, .rx_crc_ok,
		.tx_byte, .tx_last, .tx_valid, .tx_ready, .slow);
	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Clear pulses are one cycle wide, so count them as they pass
	always @(posedge clk)
		if (clear_totals === 1'b1)
			n_clear++;
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Send req, then compare the whole reply with exp; bounded wait
	task automatic xact(input logic ok);
		int l0;
		i_mrs_master_model.rsp.delete();
		l0 = i_mrs_master_model.n_last;
		@(posedge clk);
		i_mrs_master_model.send(req, ok);
		for (int w = 0; i_mrs_master_model.rsp.size() < exp.size(); w++)
		begin
			if (w == 300)
			begin
				err_total++;
				print_verdict();
			end
			@(posedge clk);
		end
		repeat (16) @(posedge clk);
		`CHK("reply length", exp.size(), i_mrs_master_model.rsp.size())
		`CHK("last flags", l0 + (exp.size() > 0), i_mrs_master_model.n_last)
		foreach (exp[i])
			`CHK("reply byte", exp[i], i_mrs_master_model.rsp[i])
	endtask
	// Register N travels as address N-1
	task automatic rdx(input logic [15:0] r, input logic [15:0] q, input logic [7:0] code);
		logic [15:0] a;
		a = r - 16'h0001;
		req = {na, 8'h03, a[15:8], a[7:0], q[15:8], q[7:0]};
		if (code != 8'h00)
			exp = {na, 8'h83, code};
		xact(1'b1);
	endtask
	// Words alternate low, high; zero code means a plain echo is expected
	task automatic wrx(input logic [15:0] r, input logic [15:0] q, input logic [15:0] lo,
		input logic [15:0] hi, input logic [7:0] code);
		logic [15:0] a;
		logic [15:0] w;
		a = r - 16'h0001;
		req = {na, 8'h10, a[15:8], a[7:0], q[15:8], q[7:0], 8'(q * 16'h0002)};
		for (int i = 0; i < q; i++)
		begin
			w = i[0] ? hi : lo;
			req = {req, w[15:8], w[7:0]};
		end
		if (code == 8'h00)
			exp = {na, 8'h10, a[15:8], a[7:0], q[15:8], q[7:0]};
		else
			exp = {na, 8'h90, code};
		xact(1'b1);
	endtask
	task automatic t_ident;
		`CHK("ready after reset", 1'b1, rx_ready)
		req = {na, 8'h11};
		exp = {na, 8'h11, 8'h02, 8'h5a, 8'hff};
		xact(1'b1);
	endtask
	task automatic t_func;
		logic [7:0] fc[4] = '{8'h01, 8'h02, 8'h04, 8'h06};
		foreach (fc[i])
		begin
			req = {na, fc[i], 8'h00, 8'h00, 8'h00, 8'h01};
			exp = {na, fc[i] | 8'h80, 8'h01};
			xact(1'b1);
		end
	endtask
	task automatic t_read;
		slow <= 1'b1;
		exp = {na, 8'h03, 8'h04, 8'hcd, 8'hef, 8'h89, 8'hab};
		rdx(16'd10, 16'd2, 8'h00);
		`CHK("rebuilt item", 32'h89abcdef, i_mrs_master_model.item32(3))
		slow <= 1'b0;
		exp = {na, 8'h03, 8'h02, 8'h89, 8'hab};
		rdx(16'd11, 16'd1, 8'h00);
		rdx(16'd10, 16'd1, 8'h02);
		rdx(16'd10, 16'd0, 8'h03);
		rdx(16'd10, 16'd126, 8'h03);
		rdx(16'hffff, 16'd4, 8'h02);
		rdx(16'd12, 16'd2, 8'h02);
	endtask
	task automatic t_write;
		wrx(16'd3, 16'd2, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd2, 16'd1, 16'h0000, 16'h0000, 8'h02);
		req[6] = 8'h04;
		exp = {na, 8'h90, 8'h03};
		xact(1'b1);
		wrx(16'd2, 16'd0, 16'h0000, 16'h0000, 8'h03);
		wrx(16'd10, 16'd2, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd12, 16'd2, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd2, 16'd17, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd256, 16'd2, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd2, 16'd2, 16'h1234, 16'h0000, 8'h00);
		`CHK("user unlock", 1'b1, user_unlocked)
		exp = {na, 8'h03, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00};
		rdx(16'd2, 16'd2, 8'h00);
		wrx(16'd256, 16'd2, 16'hffff, 16'hffff, 8'h00);
		exp = {na, 8'h03, 8'h04, 8'hff, 8'hff, 8'hff, 8'hff};
		rdx(16'd256, 16'd2, 8'h00);
		wrx(16'd6, 16'd2, 16'h9680, 16'h0098, 8'h00);
		`CHK("factory unlock", 1'b1, factory_unlocked)
		wrx(16'd512, 16'd2, 16'h5555, 16'haaaa, 8'h00);
		exp = {na, 8'h03, 8'h04, 8'h55, 8'h55, 8'haa, 8'haa};
		rdx(16'd512, 16'd2, 8'h00);
		exp = {na, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
		rdx(16'd4, 16'd2, 8'h00);
		wrx(16'd2, 16'd2, 16'h1235, 16'h0000, 8'h00);
		`CHK("user relock", 1'b0, user_unlocked)
		wrx(16'd256, 16'd2, 16'h0000, 16'h0000, 8'h02);
		wrx(16'd8, 16'd2, 16'h0001, 16'h0001, 8'h00);
		wrx(16'd8, 16'd2, 16'h0001, 16'h0000, 8'h00);
		`CHK("clear pulses", 1, n_clear)
	endtask
	task automatic t_drop;
		exp = {na, 8'h03, 8'h04, 8'hcd, 8'hef, 8'h89, 8'hab};
		rdx(16'd10, 16'd2, 8'h00);
		exp.delete();
		xact(1'b0);
		req[0] = na + 8'h01;
		xact(1'b1);
		req[0] = 8'h00;
		xact(1'b1);
	endtask
	task automatic t_settings;
		cfg_node_addr <= 8'hf8;
		repeat (3) @(posedge clk);
		`CHK("node address", 8'h01, node_addr)
		for (int i = 0; i < 8; i++)
		begin
			cfg_baud_sel <= 3'(i);
			cfg_frame_sel <= 2'(i);
			repeat (3) @(posedge clk);
			`CHK("rate", (i > 5) ? 3'h5 : 3'(i), baud_sel)
			`CHK("framing", 2'(i), frame_sel)
		end
		cfg_node_addr <= 8'hf7;
		cfg_load_defaults <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("defaults", 13'h0023, {node_addr, baud_sel, frame_sel})
		cfg_load_defaults <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("node address", 8'hf7, node_addr)
	endtask
	// Reset, then each scenario in turn
	initial
	begin
		rst = 1'b1;
		slow = 1'b0;
		na = 8'h01;
		cfg_node_addr = 8'h01;
		cfg_baud_sel = 3'h0;
		cfg_frame_sel = 2'h3;
		cfg_load_defaults = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_ident();
		t_func();
		t_read();
		t_write();
		t_drop();
		t_settings();
		print_verdict();
	end
endmodule

// [tb/mrs_request_checker_props.sv]
// Port checks for the Modbus request checker
`timescale 1ns/1ns
module mrs_request_checker_props (
	input wire clk,
	input wire rst,
	input wire [7:0] rx_byte,
	input wire rx_valid,
	input wire rx_ready,
	input wire rx_eof,
	input wire rx_crc_ok,
	input wire [7:0] tx_byte,
	input wire tx_last,
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] cfg_node_addr,
	input wire [2:0] cfg_baud_sel,
	input wire cfg_load_defaults,
	input wire [7:0] node_addr,
	input wire [2:0] baud_sel,
	input wire [1:0] frame_sel,
	input wire clear_totals
);
	logic [8:0] nb_reg;
	logic [7:0] b0_reg;
	logic [7:0] b1_reg;
	logic take;
	logic drop;
	// Byte count and first two bytes of the frame in flight
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nb_reg <= 9'h000;
			b0_reg <= 8'h00;
			b1_reg <= 8'h00;
		end
		else if (rx_eof && rx_ready)
			nb_reg <= 9'h000;
		else if (rx_valid && rx_ready)
		begin
			if (nb_reg == 9'h000)
				b0_reg <= rx_byte;
			if (nb_reg == 9'h001)
				b1_reg <= rx_byte;
			if (nb_reg != 9'h1ff)
				nb_reg <= nb_reg + 9'h001;
		end
	end
	// Only a good frame for our address may be answered; short frames never are
	assign take = rx_eof && rx_ready && rx_crc_ok && nb_reg >= 9'h002 && b0_reg == node_addr;
	assign drop = rx_eof && rx_ready && !take;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_take_blocks_rx: assert property (take |=> !rx_ready)
		else $error("request taken but receiver still ready");
	a_drop_silent: assert property (drop |=> rx_ready [*3])
		else $error("discarded frame stopped the receiver");
	a_ident_reply: assert property (take && b1_reg == 8'h11 |-> ##2 tx_valid && tx_byte == b0_reg)
		else $error("identification reply late or wrong");
	a_reply_only: assert property ($rose(tx_valid) |-> !$past(rx_ready))
		else $error("reply without a request");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_byte) && $stable(tx_last))
		else $error("reply byte changed while stalled");
	a_clear_pulse: assert property (clear_totals |=> !clear_totals)
		else $error("clear pulse longer than one cycle");
	a_load_defaults: assert property (cfg_load_defaults |=>
		node_addr == 8'h01 && baud_sel == 3'h0 && frame_sel == 2'h3)
		else $error("defaults not applied");
	a_addr_keep: assert property (!cfg_load_defaults &&
		(cfg_node_addr == 8'h00 || cfg_node_addr > 8'hf7) |=> $stable(node_addr))
		else $error("illegal node address taken");
	a_baud_track: assert property (!cfg_load_defaults && cfg_baud_sel <= 3'h5 |=>
		baud_sel == $past(cfg_baud_sel))
		else $error("rate setting not followed");
	c_ident: cover property (take && b1_reg == 8'h11);
	c_clear: cover property (clear_totals);
	c_stall: cover property (tx_valid && !tx_ready);
endmodule
bind mrs_request_checker mrs_request_checker_props i_mrs_request_checker_props (.clk, .rst,
	.rx_byte, .rx_valid, .rx_ready, .rx_eof, .rx_crc_ok, .tx_byte, .tx_last, .tx_valid,
	.tx_ready, .cfg_node_addr, .cfg_baud_sel, .cfg_load_defaults, .node_addr, .baud_sel,
	.frame_sel, .clear_totals);
